// ==== src/dtp_debug_test_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.vh"
module dtp_debug_test_port #(
   parameter [31:0] ID_CODE = `DTP_ID_DEFAULT // arbitrary value
) (
   input  wire        ref_clk,
   input  wire        reset,
   input  wire        tck,
   input  wire        tms,
   input  wire        cpu_serial_in,
   input  wire        test_reset_n,
   input  wire        chain_serial_out,
   output reg         serial_out,
   output reg         serial_out_en,
   output reg  [4:0]  active_chain,
   output reg         chain_capture,
   output reg         chain_shift,
   output reg         chain_update,
   output reg         chain_read_mode,
   output reg         chain_serial_in,
   output reg         halt_request,
   output reg         restart_request
);
   // ***********************************************************
   // pin synchronisers
   // ***********************************************************
   reg  [1:0] tck_sync;
   reg  [1:0] tms_sync;
   reg  [1:0] tdi_sync;
   reg  [1:0] trst_sync;
   reg        tck_last;
   wire       tck_rise = tck_sync[1] & ~tck_last;
   wire       tck_fall = ~tck_sync[1] & tck_last;
   wire       trst_n   = trst_sync[1];
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tck_sync  <= 2'h0;
         tms_sync  <= 2'h3;
         tdi_sync  <= 2'h0;
         trst_sync <= 2'h0;
         tck_last  <= 1'b0;
      end else begin
         tck_sync  <= {tck_sync[0], tck};
         tms_sync  <= {tms_sync[0], tms};
         tdi_sync  <= {tdi_sync[0], cpu_serial_in};
         trst_sync <= {trst_sync[0], test_reset_n};
         tck_last  <= tck_sync[1];
      end
   end
   // ***********************************************************
   // test port state machine
   // ***********************************************************
   reg  [3:0] state;
   reg  [3:0] next_state;
   wire       t = tms_sync[1];
   always @* begin
      case (state)
         `DTP_ST_RESET:    next_state = t ? `DTP_ST_RESET   : `DTP_ST_IDLE;
         `DTP_ST_IDLE:     next_state = t ? `DTP_ST_SEL_DR  : `DTP_ST_IDLE;
         `DTP_ST_SEL_DR:   next_state = t ? `DTP_ST_SEL_IR  : `DTP_ST_CAP_DR;
         `DTP_ST_CAP_DR:   next_state = t ? `DTP_ST_EXIT1_DR : `DTP_ST_SHIFT_DR;
         `DTP_ST_SHIFT_DR: next_state = t ? `DTP_ST_EXIT1_DR : `DTP_ST_SHIFT_DR;
         `DTP_ST_EXIT1_DR: next_state = t ? `DTP_ST_UPD_DR  : `DTP_ST_PAUSE_DR;
         `DTP_ST_PAUSE_DR: next_state = t ? `DTP_ST_EXIT2_DR : `DTP_ST_PAUSE_DR;
         `DTP_ST_EXIT2_DR: next_state = t ? `DTP_ST_UPD_DR  : `DTP_ST_SHIFT_DR;
         `DTP_ST_UPD_DR:   next_state = t ? `DTP_ST_SEL_DR  : `DTP_ST_IDLE;
         `DTP_ST_SEL_IR:   next_state = t ? `DTP_ST_RESET   : `DTP_ST_CAP_IR;
         `DTP_ST_CAP_IR:   next_state = t ? `DTP_ST_EXIT1_IR : `DTP_ST_SHIFT_IR;
         `DTP_ST_SHIFT_IR: next_state = t ? `DTP_ST_EXIT1_IR : `DTP_ST_SHIFT_IR;
         `DTP_ST_EXIT1_IR: next_state = t ? `DTP_ST_UPD_IR  : `DTP_ST_PAUSE_IR;
         `DTP_ST_PAUSE_IR: next_state = t ? `DTP_ST_EXIT2_IR : `DTP_ST_PAUSE_IR;
         `DTP_ST_EXIT2_IR: next_state = t ? `DTP_ST_UPD_IR  : `DTP_ST_SHIFT_IR;
         `DTP_ST_UPD_IR:   next_state = t ? `DTP_ST_SEL_DR  : `DTP_ST_IDLE;
         default:          next_state = `DTP_ST_RESET;
      endcase
   end
   // ***********************************************************
   // state strobes at the synced tck rise
   // ***********************************************************
   // a low test reset forces state, instruction, active chain and requests to reset values; shift registers and serial_out keep theirs
   wire       rise_ok     = tck_rise & trst_n;
   wire       tap_reset   = ~trst_n | (state == `DTP_ST_RESET);
   wire       at_cap_ir   = rise_ok & (state == `DTP_ST_CAP_IR);
   wire       at_shift_ir = rise_ok & (state == `DTP_ST_SHIFT_IR);
   wire       at_upd_ir   = rise_ok & (state == `DTP_ST_UPD_IR);
   wire       at_cap_dr   = rise_ok & (state == `DTP_ST_CAP_DR);
   wire       at_shift_dr = rise_ok & (state == `DTP_ST_SHIFT_DR);
   wire       at_upd_dr   = rise_ok & (state == `DTP_ST_UPD_DR);
   // entering run-test/idle from any other state
   wire       enter_idle  = rise_ok & (next_state == `DTP_ST_IDLE) &
                            (state != `DTP_ST_IDLE);
   wire       in_shift_dr = (state == `DTP_ST_SHIFT_DR);
   wire       in_shift_ir = (state == `DTP_ST_SHIFT_IR);
   wire       tdi         = tdi_sync[1];

   // ***********************************************************
   // state register
   // ***********************************************************
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= `DTP_ST_RESET;
      end else if (!trst_n) begin
         state <= `DTP_ST_RESET;
      end else if (tck_rise) begin
         state <= next_state;
      end
   end

   // ***********************************************************
   // instruction register
   // ***********************************************************
   reg  [4:0] instruction_holding;
   reg  [4:0] ir_shift;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ir_shift            <= 5'h00;
         instruction_holding <= `DTP_OP_IDCODE;
      end else if (tap_reset) begin
         instruction_holding <= `DTP_OP_IDCODE;
      end else if (at_cap_ir) begin
         ir_shift <= `DTP_IR_CAPTURE;
      end else if (at_shift_ir) begin
         ir_shift <= {tdi, ir_shift[4:1]};
      end else if (at_upd_ir) begin
         instruction_holding <= ir_shift;
      end
   end

   // ***********************************************************
   // instruction decode
   // ***********************************************************
   wire sel_extest = (instruction_holding == `DTP_OP_EXTEST);
   wire is_intest  = (instruction_holding == `DTP_OP_INTEST);
   // shortcut behaves as extest on the transfer chain
   wire sel_short  = (instruction_holding == `DTP_OP_SHORTCUT);
   wire sel_chain  = sel_extest | is_intest | sel_short;
   wire sel_cs     = (instruction_holding == `DTP_OP_CHAIN_SEL);
   wire sel_id     = (instruction_holding == `DTP_OP_IDCODE);
   // everything else, including sample/clamp/highz codes, is bypass
   wire sel_bypass = ~(sel_chain | sel_cs | sel_id);

   // ***********************************************************
   // chain select register
   // ***********************************************************
   reg  [4:0] cs_shift;
   // the shortcut opcode moves the chain already at update-ir
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cs_shift     <= 5'h00;
         active_chain <= `DTP_CS_RESET;
      end else if (tap_reset) begin
         active_chain <= `DTP_CS_RESET;
      end else if (at_cap_dr) begin
         cs_shift <= `DTP_CS_CAPTURE;
      end else if (at_shift_dr) begin
         cs_shift <= {tdi, cs_shift[4:1]};
      end else if (at_upd_ir) begin
         if (ir_shift == `DTP_OP_SHORTCUT) begin
            active_chain <= `DTP_CS_TRANSFER;
         end
      end else if (at_upd_dr) begin
         if (sel_cs) begin
            active_chain <= cs_shift;
         end
      end
   end

   // ***********************************************************
   // identification and bypass registers
   // ***********************************************************
   reg  [31:0] id_shift;
   reg         bypass_bit;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         id_shift   <= 32'h00000000;
         bypass_bit <= 1'b0;
      end else if (at_cap_dr) begin
         id_shift   <= ID_CODE;
         bypass_bit <= 1'b0;
      end else if (at_shift_dr) begin
         id_shift <= {tdi, id_shift[31:1]};
         if (sel_bypass) begin
            bypass_bit <= tdi;
         end
      end
   end

   // ***********************************************************
   // data register tail
   // ***********************************************************
   reg  dr_tail;
   always @* begin
      if (sel_chain) begin
         dr_tail = chain_serial_out;
      end else if (sel_cs) begin
         dr_tail = cs_shift[0];
      end else if (sel_id) begin
         dr_tail = id_shift[0];
      end else begin
         dr_tail = bypass_bit;
      end
   end

   // ***********************************************************
   // halt and restart requests to the core
   // ***********************************************************
   reg  halt_pending;
   reg  restart_pending;
   // an opcode latched on the very rise that enters idle is issued at once
   wire halt_now    = at_upd_ir ? (ir_shift == `DTP_OP_HALT) : halt_pending;
   wire restart_now = at_upd_ir ? (ir_shift == `DTP_OP_RESTART) : restart_pending;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         halt_pending    <= 1'b0;
         restart_pending <= 1'b0;
         halt_request    <= 1'b0;
         restart_request <= 1'b0;
      end else if (tap_reset) begin
         halt_pending    <= 1'b0;
         restart_pending <= 1'b0;
         halt_request    <= 1'b0;
         restart_request <= 1'b0;
      end else if (enter_idle) begin
         halt_pending    <= 1'b0;
         restart_pending <= 1'b0;
         halt_request    <= halt_now;
         restart_request <= restart_now;
      end else begin
         halt_request    <= 1'b0;
         restart_request <= 1'b0;
         if (at_upd_ir) begin
            halt_pending    <= (ir_shift == `DTP_OP_HALT);
            restart_pending <= (ir_shift == `DTP_OP_RESTART);
         end
      end
   end

   // ***********************************************************
   // scan chain strobes
   // ***********************************************************
   // strobes are one ref_clk wide; the chains count them
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         chain_capture   <= 1'b0;
         chain_shift     <= 1'b0;
         chain_update    <= 1'b0;
         chain_read_mode <= 1'b0;
         chain_serial_in <= 1'b0;
      end else begin
         chain_capture   <= at_cap_dr & sel_chain;
         chain_shift     <= at_shift_dr & sel_chain;
         chain_update    <= at_upd_dr & sel_chain & ~is_intest;
         chain_read_mode <= is_intest & ~tap_reset;
         if (at_shift_dr) begin
            chain_serial_in <= tdi;
         end
      end
   end

   // ***********************************************************
   // serial output on tck fall
   // ***********************************************************
   // moves on the fall so the probe finds it stable at the rise
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         serial_out    <= 1'b0;
         serial_out_en <= 1'b0;
      end else if (!trst_n) begin
         serial_out_en <= 1'b0;
      end else if (tck_fall) begin
         serial_out    <= in_shift_ir ? ir_shift[0] : dr_tail;
         serial_out_en <= in_shift_ir | in_shift_dr;
      end
   end
endmodule // dtp_debug_test_port
`default_nettype wire

// ==== src/dtp_defs.vh ====
`ifndef DTP_DEFS_VH
`define DTP_DEFS_VH
// tap states
`define DTP_ST_RESET      4'h0
`define DTP_ST_IDLE       4'h1
`define DTP_ST_SEL_DR     4'h2
`define DTP_ST_CAP_DR     4'h3
`define DTP_ST_SHIFT_DR   4'h4
`define DTP_ST_EXIT1_DR   4'h5
`define DTP_ST_PAUSE_DR   4'h6
`define DTP_ST_EXIT2_DR   4'h7
`define DTP_ST_UPD_DR     4'h8
`define DTP_ST_SEL_IR     4'h9
`define DTP_ST_CAP_IR     4'ha
`define DTP_ST_SHIFT_IR   4'hb
`define DTP_ST_EXIT1_IR   4'hc
`define DTP_ST_PAUSE_IR   4'hd
`define DTP_ST_EXIT2_IR   4'he
`define DTP_ST_UPD_IR     4'hf
// opcodes
`define DTP_OP_EXTEST     5'h00
`define DTP_OP_CHAIN_SEL  5'h02
`define DTP_OP_RESTART    5'h04
`define DTP_OP_HALT       5'h08
`define DTP_OP_INTEST     5'h0c
`define DTP_OP_SHORTCUT   5'h1d
`define DTP_OP_IDCODE     5'h1e
`define DTP_OP_BYPASS     5'h1f
// capture patterns and reset values
`define DTP_IR_CAPTURE    5'h01
`define DTP_CS_CAPTURE    5'h10
`define DTP_CS_RESET      5'h03
`define DTP_CS_TRANSFER   5'h04
`define DTP_ID_DEFAULT    32'h00000001
`endif

// ==== testbench/dtp_port_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtp_port_monitor (
   input wire logic       ref_clk,
   input wire logic       reset,
   input wire logic       tck,
   input wire logic       test_reset_n,
   input wire logic       serial_out_en,
   input wire logic [4:0] active_chain,
   input wire logic       chain_capture,
   input wire logic       chain_shift,
   input wire logic       chain_update,
   input wire logic       chain_read_mode,
   input wire logic       halt_request,
   input wire logic       restart_request
);
   // ****************************************
   // recent pin history
   // ****************************************
   logic [7:0] tck_h;
   logic [7:0] trst_h;
   always @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         tck_h  <= 8'h00;
         trst_h <= 8'hff;
      end else begin
         tck_h  <= {tck_h[6:0], tck};
         trst_h <= {trst_h[6:0], test_reset_n};
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_no_update_read: assert property (chain_update |-> !chain_read_mode)
      else $error("chain update while reading");
   a_halt_pulse: assert property (halt_request |=> !halt_request)
      else $error("halt request too long");
   a_restart_pulse: assert property (restart_request |=> !restart_request)
      else $error("restart request too long");
   a_halt_alone: assert property (halt_request |-> !restart_request && !chain_update)
      else $error("halt with other request");
   a_shift_drives: assert property (chain_shift |-> serial_out_en)
      else $error("shift without serial output");
   a_chain_cause: assert property ($changed(active_chain) |->
      (tck_h != 8'h00 && tck_h != 8'hff) || trst_h != 8'hff)
      else $error("chain changed without cause");
   a_trst_chain: assert property (!test_reset_n [*6] |=> active_chain == 5'h03)
      else $error("test reset kept chain");
   a_cap_alone: assert property (chain_capture |->
      (!chain_shift && !chain_update) ##1 !chain_capture)
      else $error("capture overlaps");
   c_update: cover property (chain_update);
   c_halt: cover property (halt_request);
   c_restart: cover property (restart_request);
endmodule // dtp_port_monitor
bind dtp_debug_test_port dtp_port_monitor mon_u (.ref_clk, .reset, .tck, .test_reset_n,
   .serial_out_en, .active_chain, .chain_capture, .chain_shift, .chain_update,
   .chain_read_mode, .halt_request, .restart_request);
`default_nettype wire

// ==== testbench/dtp_probe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dtp_probe_model (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input wire logic  tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one test clock; tdo taken while tck high, before the fall moves it
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #100 tck = 1'b1;
      #50 q = tdo;
      #50 tck = 1'b0;
   endtask
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = 32'h0;
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule // dtp_probe_model
`default_nettype wire

// ==== testbench/test_dtp_debug_test_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defs.vh"
module test_dtp_debug_test_port;
   localparam logic [31:0] ID_VAL = 32'h5a5ac3c1; // arbitrary value
   logic ref_clk, reset, test_reset_n, chain_serial_out, tck, tms, tdi, serial_out;
   logic serial_out_en, chain_capture, chain_shift, chain_update, chain_read_mode;
   logic halt_request, restart_request, q, chain_serial_in;
   logic [4:0]  active_chain;
   logic [31:0] d, sin;
   int errors, comparisons, n_halt, n_rst, n_cap, n_sh, n_upd;
   dtp_debug_test_port #(.ID_CODE(ID_VAL)) dut_u (.ref_clk, .reset, .tck, .tms,
      .cpu_serial_in(tdi), .test_reset_n, .chain_serial_out, .serial_out, .serial_out_en,
      .active_chain, .chain_capture, .chain_shift, .chain_update, .chain_read_mode,
      .chain_serial_in, .halt_request, .restart_request);
   dtp_probe_model probe_u (.tck, .tms, .tdi, .tdo(serial_out));
   always @(posedge ref_clk) begin
      n_halt += halt_request;
      n_rst += restart_request;
      n_cap += chain_capture;
      n_sh += chain_shift;
      n_upd += chain_update;
      if (chain_shift) chain_serial_out <= #1 ~chain_serial_out;
      if (chain_shift) sin = {chain_serial_in, sin[31:1]};
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic zero();
      {n_halt, n_rst, n_cap, n_sh, n_upd} = '0;
      sin = 32'h0;
   endtask
   task automatic load(input logic [4:0] op);
      probe_u.scan(1'b1, 5, {27'h0, op}, d);
      chk(d[4:0], 5'h01);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_ident();
      probe_u.scan(1'b0, 32, 32'hffffffff, d);
      chk(d, ID_VAL);
      chk(active_chain, 5'h03);
      chk(serial_out_en, 1'b0);
   endtask
   task automatic t_bypass();
      logic [4:0] ops [4] = '{`DTP_OP_BYPASS, 5'h01, 5'h05, 5'h13};
      foreach (ops[i]) begin
         load(ops[i]);
         probe_u.scan(1'b0, 8, 32'hb4, d);
         chk(d[7:0], 8'h68);
      end
   endtask
   task automatic t_select();
      load(`DTP_OP_CHAIN_SEL);
      probe_u.scan(1'b0, 5, 32'h05, d);
      chk(d[4:0], 5'h10);
      chk(active_chain, 5'h05);
   endtask
   task automatic t_chain(input logic [4:0] op);
      load(op);
      zero();
      chain_serial_out = 1'b0;
      probe_u.scan(1'b0, 6, 32'h2a, d);
      chk(d[5:0], 6'h2a);
      chk(sin[31:26], 6'h2a);
      chk(n_cap, 1);
      chk(n_sh, 6);
      chk(n_upd, op == `DTP_OP_EXTEST);
      chk(chain_read_mode, op == `DTP_OP_INTEST);
   endtask
   task automatic t_shortcut();
      load(`DTP_OP_SHORTCUT);
      chk(active_chain, 5'h04);
      load(`DTP_OP_IDCODE);
      probe_u.scan(1'b0, 32, 32'h0, d);
      chk(d, ID_VAL);
      chk(active_chain, 5'h04);
   endtask
   task automatic t_halt();
      zero();
      load(`DTP_OP_HALT);
      chk(n_halt + 2 * n_rst, 1);
      load(`DTP_OP_RESTART);
      chk(n_halt + 2 * n_rst, 3);
   endtask
   task automatic t_treset();
      @(posedge ref_clk);
      #1 test_reset_n = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1 test_reset_n = 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(active_chain, 5'h03);
      probe_u.step(1'b0, 1'b0, q);
      probe_u.scan(1'b0, 32, 32'h0, d);
      chk(d, ID_VAL);
   endtask
   task automatic close_out();
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      reset = 1'b1;
      test_reset_n = 1'b1;
      chain_serial_out = 1'b0;
      repeat (12) @(posedge ref_clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 probe_u.step(1'b0, 1'b0, q);
      t_ident();
      t_bypass();
      t_select();
      t_chain(`DTP_OP_EXTEST);
      t_chain(`DTP_OP_INTEST);
      t_shortcut();
      t_halt();
      t_treset();
      close_out();
   end
   initial begin
      #1000000;
      errors++;
      close_out();
   end
endmodule // test_dtp_debug_test_port
`default_nettype wire
